// ---- core/sep_pkg.sv ----
/*
  Constants for the serial EEPROM command port: frame lengths, opcodes,
  program cycle times and their cycle counts at the 200 MHz reference.
  Assumes a single 200 MHz reference clock in the device.
*/
package sep_pkg;
  // Reference clock
  localparam int unsigned CLK_MHZ            = 200;
  // Frame lengths in serial clocks, start bit included
  localparam int unsigned X16_SHORT_CLOCKS   = 11;
  localparam int unsigned X16_LONG_CLOCKS    = 27;
  localparam int unsigned X8_SHORT_CLOCKS    = 12;
  localparam int unsigned X8_LONG_CLOCKS     = 20;
  // Opcodes and extended sub-codes
  localparam logic [1:0]  OP_EXT             = 2'h0;
  localparam logic [1:0]  OP_WRITE           = 2'h1;
  localparam logic [1:0]  OP_READ            = 2'h2;
  localparam logic [1:0]  OP_ERASE           = 2'h3;
  localparam logic [1:0]  EXT_DISABLE        = 2'h0;
  localparam logic [1:0]  EXT_WRITE_ALL      = 2'h1;
  localparam logic [1:0]  EXT_ERASE_ALL      = 2'h2;
  localparam logic [1:0]  EXT_ENABLE         = 2'h3;
  // Program cycle times in microseconds
  localparam int unsigned WORD_LV_TIME_US    = 6000;
  localparam int unsigned WORD_5V_TIME_US    = 2000;
  localparam int unsigned ERASE_ALL_TIME_US  = 6000;
  localparam int unsigned WRITE_ALL_TIME_US  = 15000;
  // All times convert exactly to whole cycles
  localparam int unsigned WORD_LV_CYCLES     = WORD_LV_TIME_US * CLK_MHZ;
  localparam int unsigned WORD_5V_CYCLES     = WORD_5V_TIME_US * CLK_MHZ;
  localparam int unsigned ERASE_ALL_CYCLES   = ERASE_ALL_TIME_US * CLK_MHZ;
  localparam int unsigned WRITE_ALL_CYCLES   = WRITE_ALL_TIME_US * CLK_MHZ;
  // Reset values
  localparam logic        ENABLE_RESET       = 1'b0;
  // Command decoder states
  typedef enum logic [2:0] {
    SEP_IDLE, SEP_SHIFT, SEP_READ, SEP_DONE, SEP_STATUS
  } sep_state_e;
endpackage : sep_pkg

// ---- core/sep_command_port.sv ----
/*
  Serial EEPROM command front end with its word array and self-timed
  program cycle timer. Serial pins and the organisation strap arrive
  asynchronously and pass three flip-flops; all logic runs on the
  200 MHz reference. The serial output
  is split into data and enable; the pad resolves high impedance.
*/
module sep_command_port #(
  parameter int unsigned WORD_LV_CYCLES   = sep_pkg::WORD_LV_CYCLES,
  parameter int unsigned WORD_5V_CYCLES   = sep_pkg::WORD_5V_CYCLES,
  parameter int unsigned ERASE_ALL_CYCLES = sep_pkg::ERASE_ALL_CYCLES,
  parameter int unsigned WRITE_ALL_CYCLES = sep_pkg::WRITE_ALL_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Serial pins
  input  wire logic        chip_select,
  input  wire logic        serial_clk,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe,
  // Configuration straps
  input  wire logic        word_organization_select,
  input  wire logic        five_volt_variant,
  // Status
  output logic             standby,
  output logic             ready_busy_flag,
  output logic             program_enabled
);
  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when 2nd and 3rd agree
  logic [2:0] cs_sync, ck_sync, sin_sync, wsel_sync;
  logic       cs_q, ck_q, sin_q, wsel_q;

  always_ff @(posedge ref_clk) begin
    cs_sync   <= {cs_sync[1:0], chip_select};
    ck_sync   <= {ck_sync[1:0], serial_clk};
    sin_sync  <= {sin_sync[1:0], serial_in};
    wsel_sync <= {wsel_sync[1:0], word_organization_select};
  end

  // Filtered levels hold until the two late stages agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cs_q  <= 1'b0;
      ck_q  <= 1'b0;
      sin_q  <= 1'b0;
      wsel_q <= 1'b0;
    end else begin
      if (cs_sync[1] == cs_sync[2])     cs_q   <= cs_sync[2];
      if (ck_sync[1] == ck_sync[2])     ck_q   <= ck_sync[2];
      if (sin_sync[1] == sin_sync[2])   sin_q  <= sin_sync[2];
      if (wsel_sync[1] == wsel_sync[2]) wsel_q <= wsel_sync[2];
    end
  end

  logic ck_prev, cs_prev;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ck_prev <= 1'b0;
      cs_prev <= 1'b0;
    end else begin
      ck_prev <= ck_q;
      cs_prev <= cs_q;
    end
  end

  // Edge events on the filtered levels
  wire ck_rise = ck_q & ~ck_prev;
  wire cs_fall = cs_prev & ~cs_q;
  wire x16     = wsel_q;

  //////////////////////////////////////////////////////////////////////////
  // Frame decode
  sep_pkg::sep_state_e state;
  logic [4:0]  bit_cnt;     // Serial clocks taken, start bit counted
  logic [26:0] shreg;       // Opcode, address and data, MSB first
  logic [8:0]  addr;
  logic [15:0] rd_word;
  logic [4:0]  rd_cnt;
  logic        exec_pend;   // Frame complete, waiting for select fall
  logic [2:0]  exec_kind;
  logic [8:0]  exec_addr;
  logic [15:0] exec_data;
  logic [1:0]  hdr_op;      // Header fields held once the address is in
  logic [1:0]  hdr_ext;
  logic [8:0]  hdr_addr;

  wire [4:0] short_len = x16 ? 5'(sep_pkg::X16_SHORT_CLOCKS)
                             : 5'(sep_pkg::X8_SHORT_CLOCKS);
  wire [4:0] long_len  = x16 ? 5'(sep_pkg::X16_LONG_CLOCKS)
                             : 5'(sep_pkg::X8_LONG_CLOCKS);
  // Header fields as the last address bit arrives; held for the frame
  // because later data bits push them out of the low register bits
  wire [1:0] op_now   = x16 ? shreg[8:7] : shreg[9:8];
  wire [1:0] ext_now  = x16 ? shreg[6:5] : shreg[7:6];
  wire [8:0] addr_now = x16 ? {1'b0, shreg[6:0], sin_q}
                            : {shreg[7:0], sin_q};
  wire       hdr_now  = ck_rise && state == sep_pkg::SEP_SHIFT &&
                        bit_cnt == short_len - 5'h01;
  wire [1:0] opcode   = hdr_op;
  wire [1:0] ext_sel  = hdr_ext;
  wire [8:0] f_addr   = hdr_addr;
  wire       has_data = (opcode == sep_pkg::OP_WRITE) ||
                        (opcode == sep_pkg::OP_READ)  ||
                        (opcode == sep_pkg::OP_EXT &&
                         ext_sel == sep_pkg::EXT_WRITE_ALL);
  wire [4:0] need    = has_data ? long_len : short_len;
  wire       frame_in = (bit_cnt == need);
  wire [15:0] f_data = x16 ? shreg[15:0] : {8'h00, shreg[7:0]};

  //////////////////////////////////////////////////////////////////////////
  // Word array and program cycle timer
  logic [15:0] mem [0:511];
  logic        enable_latch;
  logic        busy;
  logic [31:0] timer;
  logic        status_on;   // Ready/busy shown on the output

  localparam logic [2:0] K_WRITE     = 3'h0, K_ERASE     = 3'h1;
  localparam logic [2:0] K_ERASE_ALL = 3'h2, K_WRITE_ALL = 3'h3;
  localparam logic [2:0] K_EN        = 3'h4, K_DIS       = 3'h5;
  wire [31:0] word_cycles = five_volt_variant ? 32'(WORD_5V_CYCLES)
                                              : 32'(WORD_LV_CYCLES);
  wire [31:0] term =
    (exec_kind == K_ERASE_ALL) ? 32'(ERASE_ALL_CYCLES) :
    (exec_kind == K_WRITE_ALL) ? 32'(WRITE_ALL_CYCLES) :
    word_cycles;
  wire is_prog  = exec_kind <= K_WRITE_ALL;
  wire launch   = cs_fall & exec_pend & ~busy;
  wire prog_go  = launch & is_prog & enable_latch;
  wire rd_word_bit = x16 ? rd_word[15] : rd_word[7];

  // Command decoder; select low holds it in reset
  always_ff @(posedge ref_clk) begin
    if (rst || !cs_q) begin
      state   <= sep_pkg::SEP_IDLE;
      bit_cnt <= 5'h00;
      shreg   <= 27'h0;
      rd_cnt  <= 5'h00;
      rd_word <= 16'h0000;
      addr    <= 9'h000;
      hdr_op  <= 2'h0;
      hdr_ext <= 2'h0;
      hdr_addr <= 9'h000;
    end else if (ck_rise) begin
      case (state)
        sep_pkg::SEP_IDLE: begin
          if (sin_q) begin
            state   <= busy ? sep_pkg::SEP_DONE : sep_pkg::SEP_SHIFT;
            bit_cnt <= 5'h01;
          end else if (busy || status_on) begin
            state <= sep_pkg::SEP_STATUS;
          end
        end
        sep_pkg::SEP_SHIFT: begin
          shreg   <= {shreg[25:0], sin_q};
          bit_cnt <= bit_cnt + 5'h01;
        end
        sep_pkg::SEP_READ: begin
          // Dummy zero first, then the word, then the next word
          if (rd_cnt == (x16 ? 5'd16 : 5'd8)) begin
            addr    <= x16 ? {1'b0, addr[7:0] + 8'h01} : addr + 9'h001;
            rd_word <= mem[x16 ? {1'b0, addr[7:0] + 8'h01}
                               : addr + 9'h001];
            rd_cnt  <= 5'h01;
          end else begin
            rd_word <= rd_cnt == 5'h00 ? rd_word : rd_word << 1;
            rd_cnt  <= rd_cnt + 5'h01;
          end
        end
        default: ;
      endcase
      // Header complete: hold its fields; a read fetches its word
      if (hdr_now) begin
        hdr_op   <= op_now;
        hdr_ext  <= ext_now;
        hdr_addr <= addr_now;
      end
      if (hdr_now && op_now == sep_pkg::OP_READ) begin
        state   <= sep_pkg::SEP_READ;
        addr    <= addr_now;
        rd_word <= mem[addr_now];
        rd_cnt  <= 5'h00;
      end
    end else if (state == sep_pkg::SEP_SHIFT && frame_in) begin
      state <= sep_pkg::SEP_DONE;
    end
  end

  // Pending execution is captured when the frame completes
  always_ff @(posedge ref_clk) begin
    if (rst || launch || (!cs_q && !cs_fall)) begin
      exec_pend <= 1'b0;
    end else if (state == sep_pkg::SEP_SHIFT && frame_in && !busy) begin
      exec_pend <= 1'b1;
      exec_addr <= f_addr;
      exec_data <= f_data;
      case (opcode)
        sep_pkg::OP_WRITE: exec_kind <= K_WRITE;
        sep_pkg::OP_ERASE: exec_kind <= K_ERASE;
        default: exec_kind <=
                   ext_sel == sep_pkg::EXT_ERASE_ALL ? K_ERASE_ALL :
                   ext_sel == sep_pkg::EXT_WRITE_ALL ? K_WRITE_ALL :
                             ext_sel == sep_pkg::EXT_ENABLE    ? K_EN
                                                               : K_DIS;
      endcase
    end
  end

  // Enable latch and self-timed cycle; not reset by select
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enable_latch <= sep_pkg::ENABLE_RESET;
      busy         <= 1'b0;
      timer        <= 32'h0;
    end else begin
      if (launch && exec_kind == K_EN)  enable_latch <= 1'b1;
      if (launch && exec_kind == K_DIS) enable_latch <= 1'b0;
      if (prog_go) begin
        busy  <= 1'b1;
        timer <= term - 32'h1;
      end else if (busy) begin
        if (timer == 32'h0) busy <= 1'b0;
        else timer <= timer - 32'h1;
      end
    end
  end

  // Array update once the timed cycle ends; erase writes all ones
  wire [15:0] wmask = x16 ? 16'hFFFF : 16'h00FF;
  wire        done  = busy && timer == 32'h0;
  always_ff @(posedge ref_clk) begin
    if (done) begin
      for (int i = 0; i < 512; i++) begin
        if (exec_kind == K_ERASE_ALL) mem[i] <= wmask;
        else if (exec_kind == K_WRITE_ALL) mem[i] <= exec_data & wmask;
      end
      if (exec_kind == K_WRITE) mem[exec_addr] <= exec_data & wmask;
      if (exec_kind == K_ERASE) mem[exec_addr] <= wmask;
    end
  end

  // Status display armed by a program launch, cleared by a start bit
  always_ff @(posedge ref_clk) begin
    if (rst) status_on <= 1'b0;
    else if (prog_go) status_on <= 1'b1;
    else if (cs_q && ck_rise && sin_q && state == sep_pkg::SEP_IDLE
             && !busy) status_on <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial output: read data, or ready/busy while selected
  wire show_status = cs_q && (state == sep_pkg::SEP_STATUS ||
                     (state == sep_pkg::SEP_IDLE && (busy || status_on)));
  always_ff @(posedge ref_clk) begin
    if (rst || !cs_q) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (state == sep_pkg::SEP_READ) begin
      serial_out    <= rd_cnt == 5'h00 ? 1'b0 : rd_word_bit;
      serial_out_oe <= 1'b1;
    end else begin
      serial_out    <= ~busy;
      serial_out_oe <= show_status;
    end
  end

  // Status outputs
  assign standby         = ~cs_q & ~busy;
  assign ready_busy_flag = ~busy;
  assign program_enabled = enable_latch;

  //////////////////////////////////////////////////////////////////////////
  a_out_release: assert property (@(posedge ref_clk) disable iff (rst)
    !cs_q |=> !serial_out_oe) else $error("output not released");
  a_busy_low: assert property (@(posedge ref_clk) disable iff (rst)
    serial_out_oe && state != sep_pkg::SEP_READ && $past(busy)
    |-> !serial_out) else $error("busy not low");
  a_enable_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !enable_latch |=> !$rose(busy)) else $error("program while disabled");
  a_launch_fall: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(busy) |-> $past(cs_fall)) else $error("launch without fall");
  a_no_start: assert property (@(posedge ref_clk) disable iff (rst)
    state == sep_pkg::SEP_IDLE && !(ck_rise && sin_q && cs_q)
    |=> state != sep_pkg::SEP_SHIFT) else $error("false start");
  a_dummy_zero: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(state == sep_pkg::SEP_READ) |=> !serial_out)
    else $error("no dummy zero");
  a_standby_exit: assert property (@(posedge ref_clk) disable iff (rst)
    cs_q |-> !standby) else $error("standby while selected");
  a_idle_cs_low: assert property (@(posedge ref_clk) disable iff (rst)
    !cs_q |=> state == sep_pkg::SEP_IDLE) else $error("not reset");
endmodule : sep_command_port

// ---- test/sep_host_model.sv ----
/*
  Host model for the command port: drives select, serial clock and data
  in, and samples the serial output. Assumes a 200 MHz reference and a
  bench that calls its tasks one at a time.
*/
module sep_host_model (
  // Reference clock
  input  wire logic ref_clk,
  // Serial pins
  output logic      chip_select,
  output logic      serial_clk,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each phase well above the pin filter, so no serial edge is lost
  localparam int HALF = 8;
  logic [63:0] rx;
  logic [63:0] rx_oe;
  initial begin
    chip_select = 1'h0;
    serial_clk  = 1'h0;
    serial_in   = 1'h0;
  end
  //////////////////////////////////////////////////////////////////////
  // Send bits MSB first; the output is sampled late in each high phase
  task automatic shift(input logic [63:0] bits, input int n);
    @(posedge ref_clk);
    chip_select <= 1'h1;
    repeat (HALF) @(posedge ref_clk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= bits[i];
      repeat (HALF) @(posedge ref_clk);
      serial_clk <= 1'h1;
      repeat (HALF) @(posedge ref_clk);
      // A released line shows the inverse of the driven value
      rx    = {rx[62:0], serial_out_oe ? serial_out : ~serial_out};
      rx_oe = {rx_oe[62:0], serial_out_oe};
      serial_clk <= 1'h0;
    end
  endtask : shift
  // Select low for longer than the minimum gap between frames
  task automatic deselect();
    @(posedge ref_clk);
    chip_select <= 1'h0;
    serial_in   <= 1'h0;
    repeat (60) @(posedge ref_clk);
  endtask : deselect
endmodule : sep_host_model

// ---- test/serial_eeprom_command_port_tb.sv ----
/*
  Self-checking bench: a table of frames in both organisations, then a
  second reset, idle activity, a short frame and a streamed read.
  Assumes sep_host_model drives the serial pins.
*/
module serial_eeprom_command_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short cycle counts keep the run brief
  localparam int unsigned LV = 400;
  localparam int unsigned FV = 200;
  localparam int unsigned EA = 300;
  localparam int unsigned WA = 500;
  typedef struct {
    logic wide; logic fv; logic [1:0] op; logic [8:0] addr;
    logic [15:0] data; logic busy; logic en; logic [15:0] exp;
  } sep_row_s;
  logic ref_clk, rst, chip_select, serial_clk, serial_in, serial_out;
  logic serial_out_oe, wide, fv, standby, ready_busy_flag, program_enabled;
  int   num_errors, num_checks, cyc;
  // Columns: wide, fv, op, addr, data, busy, enabled after, read data
  sep_row_s rows [22] = '{
    '{1'h1, 1'h0, 2'h0, 9'h0C0, 16'h0000, 1'h0, 1'h1, 16'h0000},
    '{1'h1, 1'h0, 2'h1, 9'h005, 16'hA5C3, 1'h1, 1'h1, 16'h0000},
    '{1'h1, 1'h1, 2'h1, 9'h006, 16'h3C5A, 1'h1, 1'h1, 16'h0000},
    '{1'h1, 1'h0, 2'h2, 9'h005, 16'h0000, 1'h0, 1'h1, 16'hA5C3},
    '{1'h1, 1'h0, 2'h0, 9'h000, 16'h0000, 1'h0, 1'h0, 16'h0000},
    '{1'h1, 1'h0, 2'h1, 9'h005, 16'h1234, 1'h0, 1'h0, 16'h0000},
    '{1'h1, 1'h0, 2'h2, 9'h005, 16'h0000, 1'h0, 1'h0, 16'hA5C3},
    '{1'h1, 1'h0, 2'h0, 9'h0C0, 16'h0000, 1'h0, 1'h1, 16'h0000},
    '{1'h1, 1'h0, 2'h3, 9'h005, 16'h0000, 1'h1, 1'h1, 16'h0000},
    '{1'h1, 1'h0, 2'h2, 9'h005, 16'h0000, 1'h0, 1'h1, 16'hFFFF},
    '{1'h1, 1'h0, 2'h0, 9'h040, 16'h0F0F, 1'h1, 1'h1, 16'h0000},
    '{1'h1, 1'h0, 2'h2, 9'h00A, 16'h0000, 1'h0, 1'h1, 16'h0F0F},
    '{1'h1, 1'h0, 2'h0, 9'h080, 16'h0000, 1'h1, 1'h1, 16'h0000},
    '{1'h1, 1'h0, 2'h2, 9'h00A, 16'h0000, 1'h0, 1'h1, 16'hFFFF},
    '{1'h0, 1'h1, 2'h1, 9'h1F3, 16'h005A, 1'h1, 1'h1, 16'h0000},
    '{1'h0, 1'h0, 2'h2, 9'h1F3, 16'h0000, 1'h0, 1'h1, 16'h005A},
    '{1'h0, 1'h0, 2'h0, 9'h080, 16'h0081, 1'h1, 1'h1, 16'h0000},
    '{1'h0, 1'h0, 2'h2, 9'h100, 16'h0000, 1'h0, 1'h1, 16'h0081},
    '{1'h0, 1'h0, 2'h0, 9'h100, 16'h0000, 1'h1, 1'h1, 16'h0000},
    '{1'h0, 1'h0, 2'h0, 9'h000, 16'h0000, 1'h0, 1'h0, 16'h0000},
    '{1'h0, 1'h0, 2'h0, 9'h180, 16'h0000, 1'h0, 1'h1, 16'h0000},
    '{1'h0, 1'h0, 2'h2, 9'h000, 16'h0000, 1'h0, 1'h1, 16'h00FF}};
  sep_command_port #(.WORD_LV_CYCLES(LV), .WORD_5V_CYCLES(FV),
    .ERASE_ALL_CYCLES(EA), .WRITE_ALL_CYCLES(WA)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .chip_select(chip_select),
    .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .word_organization_select(wide), .five_volt_variant(fv),
    .standby(standby), .ready_busy_flag(ready_busy_flag),
    .program_enabled(program_enabled));
  sep_host_model u_host (
    .ref_clk(ref_clk), .chip_select(chip_select),
    .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  //////////////////////////////////////////////////////////////////////
  // Clock, cycle count and a watchdog against any hang
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;
  initial begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    final_report();
  end
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'h1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////
  // One frame; a busy frame is polled on the output, then cleared
  task automatic run_row(input sep_row_s r);
    logic [63:0] bits, m;
    logic [1:0]  sub;
    int          n, w, lim, t0;
    @(posedge ref_clk);
    wide <= r.wide;
    fv   <= r.fv;
    w   = r.wide ? 16 : 8;
    sub = r.wide ? r.addr[7:6] : r.addr[8:7];
    bits = r.wide ? {1'h1, r.op, r.addr[7:0], r.data}
                  : {1'h1, r.op, r.addr, r.data[7:0]};
    n = w + (r.wide ? 11 : 12);
    if (r.op[0] == r.op[1] && !(r.op == 2'h0 && sub == 2'h1)) begin
      bits = bits >> w;
      n = n - w;
    end
    u_host.shift(bits, n);
    m = (64'h1 << (w + 1)) - 64'h1;
    if (r.op == sep_pkg::OP_READ) begin
      check((u_host.rx & m) === {48'h0, r.exp}, "read data");
      check((u_host.rx_oe & (2 * m + 1)) === m, "read enable");
    end
    t0 = cyc;
    u_host.deselect();
    check(serial_out_oe === 1'h0, "output not released");
    lim = (r.op != 2'h0) ? (r.fv ? FV : LV) : ((sub == 2'h2) ? EA : WA);
    if (r.busy) begin
      check(ready_busy_flag === 1'h0 && standby === 1'h0, "no busy");
      u_host.shift(64'h0, 0);
      check(serial_out_oe === 1'h1 && serial_out === 1'h0, "status");
      for (int k = 0; k < 4000 && serial_out !== 1'h1; k++) begin
        @(posedge ref_clk);
      end
      check(serial_out === 1'h1 && cyc - t0 <= lim + 40, "late");
      if (serial_out !== 1'h1) final_report();
      u_host.shift(64'h1, 1);
      u_host.deselect();
    end else begin
      check(ready_busy_flag === 1'h1, "program ran");
    end
    check(program_enabled === r.en, "enable latch");
    $display("test done: op %0h wide %0h", r.op, r.wide);
  endtask : run_row
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'h1;
    wide = 1'h1;
    fv  = 1'h0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (8) @(posedge ref_clk);
    foreach (rows[i]) run_row(rows[i]);
    // Second reset in mid-run clears the enable latch
    rst <= 1'h1;
    repeat (12) @(posedge ref_clk);
    check(program_enabled === 1'h0 && serial_out_oe === 1'h0, "rst");
    rst <= 1'h0;
    repeat (8) @(posedge ref_clk);
    $display("test done: reset");
    // Select and clocks without a start bit do nothing
    u_host.shift(64'h0, 0);
    check(standby === 1'h0, "standby");
    u_host.shift(64'h0, 12);
    check(serial_out_oe === 1'h0 && ready_busy_flag === 1'h1, "idle");
    u_host.deselect();
    check(standby === 1'h1, "standby back");
    $display("test done: idle");
    // Short write frame is dropped; streamed read crosses addresses
    run_row('{1'h1, 1'h0, 2'h0, 9'h0C0, 16'h0, 1'h0, 1'h1, 16'h0});
    run_row('{1'h1, 1'h0, 2'h1, 9'h010, 16'h1111, 1'h1, 1'h1, 16'h0});
    run_row('{1'h1, 1'h0, 2'h1, 9'h011, 16'h2222, 1'h1, 1'h1, 16'h0});
    u_host.shift({37'h0, 3'h5, 8'h11, 16'h9999} >> 1, 26);
    u_host.deselect();
    check(ready_busy_flag === 1'h1, "short frame ran");
    u_host.shift({37'h0, 3'h6, 8'h10, 16'h0}, 27);
    u_host.shift(64'h0, 16);
    check(u_host.rx[32:0] === {1'h0, 16'h1111, 16'h2222}, "stream");
    u_host.deselect();
    $display("test done: short frame and stream");
    final_report();
  end
endmodule : serial_eeprom_command_port_tb
